/* File: logic/nand_host.sv */
// Host controller: reads the parameter page and polls status of a NAND device.
// Assumes the device pins are wired directly; one 200 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "nand_host_cfg.svh"
module nand_host (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       op_valid,
  input  wire logic [1:0] op_code,
  output logic            op_ready,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  input  wire logic       rd_ready,
  output logic [7:0]      status_q,
  output logic            status_fail,
  output logic            status_cache_fail,
  output logic            array_ready,
  output logic            write_protected,
  output logic            crc_ok,
  output logic            crc_done,
  output logic            busy,
  output logic            chip_select_n,
  output logic            cmd_latch,
  output logic            addr_latch,
  output logic            write_strobe_n,
  output logic            read_strobe_n,
  output logic [7:0]      io_out,
  output logic            io_oe_n,
  input  wire logic [7:0] io_in
);
  nand_host_pkg::state_type state_q;
  nand_host_pkg::op_type    op_q;
  logic [7:0]  io_s1_q;
  logic [7:0]  io_s2_q;
  logic [7:0]  io_s3_q;
  logic [7:0]  io_q;
  logic [7:0]  tmr_q;
  logic [9:0]  idx_q;
  logic [15:0] crc_q;
  logic [15:0] crc_rx_q;
  logic        strobe_lo_q;
  logic        crc_ok_q;
  logic        crc_done_q;
  logic        status_mode_q;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        tick;

  // MSB-first CRC byte update, no reflection
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Three-stage sampling; a change counts when stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
      io_s3_q <= 8'h00;
      io_q    <= 8'h00;
    end else begin
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
      io_s3_q <= io_s2_q;
      if (io_s2_q == io_s3_q) begin
        io_q <= io_s3_q;
      end
    end
  end

  assign tick          = (tmr_q == 8'h00);
  assign op_ready      = (state_q == nand_host_pkg::S_IDLE);
  assign busy          = !op_ready;
  assign fifo_in_valid = (state_q == nand_host_pkg::S_RD) && tick && strobe_lo_q
                         && (op_q != nand_host_pkg::OP_STATUS);
  assign crc_ok        = crc_ok_q;
  assign crc_done      = crc_done_q;
  assign status_fail       = status_q[`ST_FAIL_BIT] && status_q[`ST_ARRAY_RDY_BIT];
  assign status_cache_fail = status_q[`ST_CACHE_FAIL_BIT];
  assign array_ready       = status_q[`ST_ARRAY_RDY_BIT];
  assign write_protected   = !status_q[`ST_WP_N_BIT];

  // Sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q        <= nand_host_pkg::S_IDLE;
      op_q           <= nand_host_pkg::OP_STATUS;
      tmr_q          <= 8'h00;
      idx_q          <= 10'd0;
      strobe_lo_q    <= 1'b0;
      chip_select_n  <= 1'b1;
      cmd_latch      <= 1'b0;
      addr_latch     <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n  <= 1'b1;
      io_out         <= 8'h00;
      io_oe_n        <= 1'b1;
      status_mode_q  <= 1'b0;
    end else begin
      if (!tick) begin
        tmr_q <= tmr_q - 8'h01;
      end
      case (state_q)
        nand_host_pkg::S_IDLE: begin
          if (op_valid) begin
            op_q          <= nand_host_pkg::op_type'(op_code);
            chip_select_n <= 1'b0;
            cmd_latch     <= 1'b1;
            io_oe_n       <= 1'b0;
            idx_q         <= 10'd0;
            strobe_lo_q   <= 1'b0;
            tmr_q         <= 8'(`STROBE_CYC);
            case (nand_host_pkg::op_type'(op_code))
              nand_host_pkg::OP_STATUS: io_out <= `CMD_READ_STATUS;
              nand_host_pkg::OP_RESUME: io_out <= `CMD_READ_MODE;
              default:                  io_out <= `CMD_READ_PARAM;
            endcase
            write_strobe_n <= 1'b0;
            state_q        <= nand_host_pkg::S_CMD;
          end
        end
        nand_host_pkg::S_CMD: begin
          if (tick) begin
            write_strobe_n <= 1'b1;
            cmd_latch      <= 1'b0;
            status_mode_q  <= (op_q == nand_host_pkg::OP_STATUS);
            tmr_q          <= 8'(`CCS_CYC);
            if (op_q == nand_host_pkg::OP_PARAM) begin
              addr_latch <= 1'b1;
              io_out     <= 8'h00;
              state_q    <= nand_host_pkg::S_ADDR;
            end else if (op_q == nand_host_pkg::OP_RESUME) begin
              io_oe_n <= 1'b1;
              state_q <= nand_host_pkg::S_DONE;
            end else begin
              io_oe_n <= 1'b1;
              state_q <= nand_host_pkg::S_GAP;
            end
          end
        end
        nand_host_pkg::S_ADDR: begin
          if (tick && write_strobe_n) begin
            write_strobe_n <= 1'b0;
            tmr_q          <= 8'(`STROBE_CYC);
          end else if (tick) begin
            write_strobe_n <= 1'b1;
            addr_latch     <= 1'b0;
            io_oe_n        <= 1'b1;
            tmr_q          <= 8'(`STROBE_CYC);
            state_q        <= nand_host_pkg::S_WAIT;
          end
        end
        nand_host_pkg::S_WAIT: begin
          // Poll status until the array read finishes
          if (tick && read_strobe_n) begin
            read_strobe_n <= 1'b0;
            tmr_q         <= 8'(`STROBE_CYC);
          end else if (tick) begin
            read_strobe_n <= 1'b1;
            tmr_q         <= 8'(`STROBE_CYC);
            if (io_q[`ST_ARRAY_RDY_BIT]) begin
              state_q <= nand_host_pkg::S_GAP;
            end
          end
        end
        nand_host_pkg::S_GAP: begin
          if (tick) begin
            tmr_q   <= 8'(`STROBE_CYC);
            state_q <= nand_host_pkg::S_RD;
          end
        end
        nand_host_pkg::S_RD: begin
          if (tick && !strobe_lo_q) begin
            read_strobe_n <= 1'b0;
            strobe_lo_q   <= 1'b1;
            tmr_q         <= 8'(`STROBE_CYC);
          end else if (tick && (fifo_in_ready || op_q == nand_host_pkg::OP_STATUS)) begin
            read_strobe_n <= 1'b1;
            strobe_lo_q   <= 1'b0;
            tmr_q         <= 8'(`STROBE_CYC);
            idx_q         <= idx_q + 10'd1;
            if (op_q == nand_host_pkg::OP_STATUS ||
                idx_q == `PP_COPY_LEN - 10'd1) begin
              state_q <= nand_host_pkg::S_DONE;
            end
          end
        end
        nand_host_pkg::S_DONE: begin
          if (tick) begin
            chip_select_n <= 1'b1;
            state_q       <= nand_host_pkg::S_IDLE;
          end
        end
        default: state_q <= nand_host_pkg::S_IDLE;
      endcase
    end
  end

  // Status capture from the read cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= 8'h00;
    end else if (state_q == nand_host_pkg::S_RD && tick && strobe_lo_q && op_q == nand_host_pkg::OP_STATUS) begin
      status_q <= io_q & ~`ST_ZERO_MASK;
    end
  end

  // Parameter page CRC over bytes 0-253, compare with 254-255
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_q      <= `CRC_INIT;
      crc_rx_q   <= 16'h0000;
      crc_ok_q   <= 1'b0;
      crc_done_q <= 1'b0;
    end else if (state_q == nand_host_pkg::S_IDLE && op_valid &&
                 nand_host_pkg::op_type'(op_code) == nand_host_pkg::OP_PARAM) begin
      crc_q      <= `CRC_INIT;
      crc_done_q <= 1'b0;
      crc_ok_q   <= 1'b0;
    end else if (fifo_in_valid && fifo_in_ready) begin
      if (idx_q < `PP_CRC_LO) begin
        crc_q <= crc_step(crc_q, io_q);
      end else if (idx_q == `PP_CRC_LO) begin
        crc_rx_q[7:0] <= io_q;
      end else begin
        crc_rx_q[15:8] <= io_q;
        crc_ok_q       <= ({io_q, crc_rx_q[7:0]} == crc_q);
        crc_done_q     <= 1'b1;
      end
    end
  end

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (io_q),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (rd_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready)
  );

  logic unused_status_mode;
  assign unused_status_mode = status_mode_q;
endmodule
`default_nettype wire

/* File: shared/nand_host_cfg.svh */
// Constants for the NAND parameter-page and status host controller.
// Included by the nand_host design file only; definitions only.
`ifndef NAND_HOST_CFG_SVH
`define NAND_HOST_CFG_SVH

`define CMD_READ_STATUS     8'h70
`define CMD_READ_MODE       8'h00
`define CMD_READ_PARAM      8'hec
`define CMD_READ_CONFIRM    8'h30
`define CRC_POLY            16'h8005
`define CRC_INIT            16'h4f4e
`define PP_CRC_LO           10'd254
`define PP_CRC_HI           10'd255
`define PP_COPY_LEN         10'd256
`define PP_COPIES           2'd3
`define ST_FAIL_BIT         0
`define ST_CACHE_FAIL_BIT   1
`define ST_ARRAY_RDY_BIT    5
`define ST_CACHE_RDY_BIT    6
`define ST_WP_N_BIT         7
`define ST_ZERO_MASK        8'h14
`define CLK_PERIOD_NS       5
`define STROBE_NS           25
`define STROBE_CYC          (((`STROBE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define CCS_NS              60
`define CCS_CYC             (((`CCS_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define FIFO_DEPTH          8

`endif

/* File: shared/nand_host_pkg.sv */
// Types for the NAND host controller.
// Assumes nothing of its surroundings.
package nand_host_pkg;
  typedef enum logic [1:0] {
    OP_STATUS,
    OP_PARAM,
    OP_RESUME
  } op_type;

  typedef enum {
    S_IDLE,
    S_CMD,
    S_ADDR,
    S_WAIT,
    S_RD,
    S_GAP,
    S_DONE
  } state_type;
endpackage

/* File: logic/byte_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

/* File: tb/nand_host_asserts.sv */
// Checker of the host controller's status flags and handshake.
// Bound to nand_host; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module nand_host_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       op_valid,
  input wire logic       op_ready,
  input wire logic       busy,
  input wire logic [7:0] status_q,
  input wire logic       status_fail,
  input wire logic       array_ready,
  input wire logic       write_protected,
  input wire logic       crc_ok,
  input wire logic       crc_done,
  input wire logic       cmd_latch,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic       io_oe_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_take_busy: assert property (op_valid && op_ready |=> busy && !op_ready)
    else $error("op not taken");
  a_wp_flag: assert property (write_protected == !status_q[7])
    else $error("wp flag");
  a_zero_bits: assert property (status_q[2] == 1'b0 && status_q[4] == 1'b0)
    else $error("zero bits");
  a_fail_flag: assert property (status_fail == (status_q[0] && status_q[5]))
    else $error("fail flag");
  a_array_rdy: assert property (array_ready == status_q[5])
    else $error("ready flag");
  a_cmd_drive: assert property (cmd_latch && !write_strobe_n |-> !io_oe_n)
    else $error("cmd not driven");
  a_read_release: assert property (!read_strobe_n |-> io_oe_n && !cmd_latch)
    else $error("bus not released");
  a_crc_hold: assert property (crc_done && !busy && !op_valid |=> $stable(crc_ok) && crc_done)
    else $error("crc flag moved");
endmodule
bind nand_host nand_host_asserts u_nand_host_asserts (
  .clk(clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready), .busy(busy),
  .status_q(status_q), .status_fail(status_fail), .array_ready(array_ready),
  .write_protected(write_protected), .crc_ok(crc_ok), .crc_done(crc_done), .cmd_latch(cmd_latch),
  .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_oe_n(io_oe_n)
);
`default_nettype wire

/* File: tb/nand_dev_model.sv */
// Behavioural NAND device: status register and parameter page.
// Driven by the host pins; bench sets protect, fail bits, crc fault.
`timescale 1ns/10ps
`default_nettype none
module nand_dev_model (
  input wire logic       clk,
  input wire logic       chip_select_n,
  input wire logic       cmd_latch,
  input wire logic       addr_latch,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic [7:0] io_out,
  input wire logic       wp_on,
  input wire logic [1:0] fail_bits,
  input wire logic       bad_crc,
  output logic     [7:0] io_in
);
  localparam logic [151:0] BLK_A = 152'h00040000012201140001050101050400040000;
  localparam logic [103:0] BLK_B = 104'h06070007_00bc0210271900_3c00;
  logic [7:0] page [256];
  logic [7:0] ptr = 8'h00, last = 8'h00, cap_io = 8'h00, status, val;
  logic [1:0] mode = 2'd0;
  logic       we_q = 1'b1, re_q = 1'b1, cap_cmd = 1'b0, cap_addr = 1'b0;
  int         busy_cnt = 0;
  initial begin
    logic [15:0] c;
    for (int i = 0; i < 256; i++) page[i] = (i < 96) ? 8'(i) : 8'h00;
    for (int i = 0; i < 19; i++) page[96+i] = BLK_A[8*(18-i)+:8];
    for (int i = 0; i < 13; i++) page[128+i] = BLK_B[8*(12-i)+:8];
    c = 16'h4f4e;
    for (int i = 0; i < 254; i++) begin
      c = c ^ {page[i], 8'h00};
      for (int b = 0; b < 8; b++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h8005 : {c[14:0], 1'b0};
    end
    page[254] = c[7:0];
    page[255] = c[15:8];
  end
  // Live status, no strobe toggle needed
  assign status = {!wp_on, busy_cnt == 0, busy_cnt == 0, 3'b000, fail_bits};
  // Pointer wraps, so copies repeat
  assign val = (mode == 2'd0) ? page[ptr] ^ {8{ptr == 8'd254 && bad_crc}} : status;
  assign io_in = (!chip_select_n && !read_strobe_n) ? val : ~last;
  always @(posedge clk) begin
    we_q <= write_strobe_n;
    re_q <= read_strobe_n;
    // Busy count holds while strobe low, so one read sees one value
    if (busy_cnt > 0 && read_strobe_n) busy_cnt <= busy_cnt - 1;
    if (!chip_select_n && !read_strobe_n) last <= val;
    if (!chip_select_n && !write_strobe_n) begin
      cap_cmd <= cmd_latch;
      cap_addr <= addr_latch;
      cap_io <= io_out;
    end
    if (write_strobe_n && !we_q && !chip_select_n) begin
      if (cap_cmd) mode <= (cap_io == 8'h70) ? 2'd1 : ((cap_io == 8'hec) ? 2'd2 : 2'd0);
      if (cap_cmd && cap_io == 8'hec) ptr <= 8'h00;
      if (cap_addr) busy_cnt <= 200;
    end
    if (read_strobe_n && !re_q && !chip_select_n) begin
      if (mode == 2'd0) ptr <= ptr + 8'h01;
      if (mode == 2'd2 && busy_cnt == 0) mode <= 2'd0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/nand_host_tb_top.sv */
// Self-checking bench for nand_host against a behavioural device.
// One 200 MHz clock; the device model sits on the pins.
`timescale 1ns/10ps
`default_nettype none
module nand_host_tb_top;
  logic clk = 1'b0, rst = 1'b1, op_valid = 1'b0, rd_ready = 1'b0, wp_on = 1'b0, bad_crc = 1'b0;
  logic [1:0] op_code = 2'd0, fail_bits = 2'd0;
  logic [7:0] rd_data, status_q, io_out, io_in;
  logic op_ready, rd_valid, status_fail, status_cache_fail, array_ready, write_protected, crc_ok;
  logic crc_done, busy, chip_select_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n, io_oe_n;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  nand_host u_nand_host (
    .clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .op_ready(op_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .status_q(status_q),
    .status_fail(status_fail), .status_cache_fail(status_cache_fail), .array_ready(array_ready),
    .write_protected(write_protected), .crc_ok(crc_ok), .crc_done(crc_done), .busy(busy),
    .chip_select_n(chip_select_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
    .io_oe_n(io_oe_n), .io_in(io_in)
  );
  nand_dev_model u_nand_dev_model (
    .clk(clk), .chip_select_n(chip_select_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
    .wp_on(wp_on), .fail_bits(fail_bits), .bad_crc(bad_crc), .io_in(io_in)
  );
  task automatic end_sim;
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (op_ready !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h0, op_ready}, 8'h01, "idle");
  endtask
  task automatic start_op(input logic [1:0] code);
    wait_idle();
    op_valid = 1'b1;
    op_code = code;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    chk({7'h0, busy}, 8'h01, "taken");
  endtask
  task automatic t_status(input logic wp, input logic [1:0] fb);
    wp_on = wp;
    fail_bits = fb;
    start_op(2'd0);
    wait_idle();
    chk(status_q, {!wp, 2'b11, 3'b000, fb}, "status");
    chk({status_fail, status_cache_fail, array_ready, write_protected}, {fb[0], fb[1], 1'b1, wp}, "flags");
  endtask
  task automatic t_param(input logic bad);
    int n, k;
    bad_crc = bad;
    rd_ready = 1'b0;
    start_op(2'd1);
    repeat (600) @(posedge clk);
    #1;
    chk({6'h0, rd_valid, busy}, 8'h03, "stalled");
    n = 0;
    k = 0;
    while (n < 256 && k < 30000) begin
      @(negedge clk);
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        chk(rd_data, u_nand_dev_model.page[n] ^ {8{n == 254 && bad}}, "byte");
        n++;
      end
      @(posedge clk);
      #1;
      rd_ready = (k % 4 != 0);
      k++;
    end
    chk({7'h0, n == 256}, 8'h01, "count");
    wait_idle();
    chk({crc_done, crc_ok}, {1'b1, !bad}, "crc");
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    t_status(1'b0, 2'b00);
    t_status(1'b1, 2'b11);
    t_param(1'b0);
    t_status(1'b0, 2'b01);
    start_op(2'd2);
    t_param(1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
